//--- shared/fault_monitor_cfg.svh
// Offsets, field positions, reset values and timing counts of the fault monitor
`ifndef FAULT_MONITOR_CFG_SVH
`define FAULT_MONITOR_CFG_SVH
`define ADDR_CTRL       8'h00
`define ADDR_FRESET     8'h04
`define ADDR_WARN       8'h08
`define ADDR_FAULT      8'h0C
`define ADDR_STATE      8'h10
`define ADDR_CFG_BASE   8'h20
`define CFG_N           14
`define CFG_CUR_WARN    4'h0
`define CFG_CUR_FAULT   4'h1
`define CFG_SPD_WARN    4'h2
`define CFG_SPD_FAULT   4'h3
`define CFG_DC_WARN     4'h4
`define CFG_DC_FAULT    4'h5
`define CFG_MT_WARN     4'h6
`define CFG_MT_FAULT    4'h7
`define CFG_ALIGN_MAX   4'h8
`define CFG_CONNECT_V   4'h9
`define CFG_PRECHG_TO   4'hA
`define CFG_CAN_TO      4'hB
`define CFG_SKIP01      4'hC
`define CFG_SKIP2       4'hD
`define CFG_TH_RST      32'h0000_FFFF
`define CFG_TO_RST      32'h0000_0000
`define CTRL_RST        8'h00
`define CTRL_MT_EN      0
`define CTRL_PROF_EN    1
`define CTRL_DER_MOT    2
`define CTRL_DER_INV    3
`define CTRL_FOLD_EN    4
`define CTRL_PM_MOTOR   5
`define CTRL_PRECHG_EN  6
`define INV_WARN_SET    16'd110
`define INV_WARN_CLR    16'd105
`define PCB_WARN_SET    16'd85
`define PCB_WARN_CLR    16'd80
`define INV_FAULT_TH    16'd115
`define PCB_FAULT_TH    16'd90
`define FAULT_KEEP      15'h0800
`define CLK_MHZ         200
`define TICK_NS         1000
`define TICK_CYC        ((`TICK_NS * `CLK_MHZ + 999) / 1000)
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

//--- shared/fault_monitor_pkg.sv
// Types shared by the fault monitor and its bench
package fault_monitor_pkg;
    typedef struct packed {
        logic [15:0] inv_temp;
        logic [15:0] pcb_temp;
        logic [15:0] mot_temp;
        logic [15:0] current;
        logic [15:0] speed;
        logic [15:0] dc_volt;
        logic [15:0] torque_req;
        logic [15:0] profile_max;
        logic [15:0] command;
    } meas_type;
    typedef struct packed {
        logic desat;
        logic gate_fault;
        logic hw_ovp;
        logic interlock;
        logic fault_clr;
        logic rail15_bad;
        logic rail5_bad;
    } pins_type;
    typedef struct packed {
        logic crc_err;
        logic cal_fail;
        logic can_rx;
        logic turn_on;
        logic turn_off;
        logic charge_start;
        logic cal_done;
        logic cal_req;
        logic derate_mot;
        logic derate_inv;
        logic foldback;
    } evt_type;
    typedef enum logic [6:0] {
        st_init      = 7'h01,
        st_calibrate = 7'h02,
        st_chg_wait  = 7'h04,
        st_charging  = 7'h08,
        st_idle      = 7'h10,
        st_run       = 7'h20,
        st_fault     = 7'h40
    } state_type;
endpackage

//--- rtl/drive_fault_warning_monitor.sv
// Fault and warning supervisor with drive sequencer and AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fault_monitor_cfg.svh"
// Function
// - Warnings only report, never stop drive
// - Inverter temp warning 110 set, 105 clear
// - Board temp warning 85 set, 80 clear
// - Current, speed, DC warnings with recovery delta
// - Motor temp warning only when sensing enabled
// - Clamp torque to profile max, flag it
// - Derating warning while enabled derating active
// - Foldback warning while foldback reduces current
// - Skip-zone flag while command inside zone
// - One flag per 15V and 5V rail
// - Fault disables inverter, enters fault state
// - Faults persist until reset or clear
// - Reset clears, re-latches, exits if none
// - Latch desat, gate, HW OVP, interlock faults
// - Faults above 115 inverter, 90 board
// - Current, speed, DC over-threshold faults
// - Motor over-temp fault only when enabled
// - PM align fault on fast turn-on
// - Pre-charge timeout fault
// - CRC fault survives every clear
// - Calibration failure fault
// - CAN message gap timeout fault
module drive_fault_warning_monitor (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Measurements, pins and drive events
    input  wire fault_monitor_pkg::meas_type meas,
    input  wire fault_monitor_pkg::pins_type pins,
    input  wire fault_monitor_pkg::evt_type  evt,
    // Drive outputs and alarm words
    output logic                             inverter_en,
    output logic [15:0]                      torque_applied_ff,
    output fault_monitor_pkg::state_type     drive_state,
    output logic [11:0]                      warn_word,
    output logic [14:0]                      fault_word
);
    import fault_monitor_pkg::*;

    // Hysteresis flag: set above set_th, clear below clr_th
    function automatic logic hyst(input logic f, input logic [15:0] v,
                                  input logic [15:0] s, input logic [15:0] c);
        hyst = f ? !(v < c) : (v > s);
    endfunction

    // Clear level of threshold minus delta, floored at zero
    function automatic logic [15:0] clr_lvl(input logic [31:0] r);
        clr_lvl = (r[15:0] > r[31:16]) ? r[15:0] - r[31:16] : 16'h0000;
    endfunction

    // Inside one skip zone of half width band
    function automatic logic in_zone(input logic [15:0] v, input logic [15:0] c,
                                     input logic [15:0] b);
        logic [15:0] d;
        d = (v > c) ? v - c : c - v;
        in_zone = d < b;
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        merge = o;
    endfunction

    logic [6:0]  sync1_ff;
    logic [6:0]  sync2_ff;
    pins_type    pin_s;

    // Two-stage synchronisers for the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 7'h00;
            sync2_ff <= 7'h00;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
        end
    end
    assign pin_s = pins_type'(sync2_ff);

    logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
    logic [7:0]  awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [3:0]  ws_ff, nxt_ws;
    logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
    logic [7:0]  ctrl_ff, nxt_ctrl;
    logic [31:0] cfg_ff [`CFG_N];
    logic [31:0] nxt_cfg [`CFG_N];
    logic        freset;
    logic        do_wr;
    logic [7:0]  cfg_off;
    logic [11:0] warn_ff, nxt_warn;
    logic [14:0] fault_ff, nxt_fault, src;
    state_type   state_ff, nxt_state;

    assign s_axi_awready = !aw_ff && !bv_ff;
    assign s_axi_wready  = !w_ff && !bv_ff;
    assign s_axi_arready = !rv_ff;
    assign s_axi_bvalid  = bv_ff;
    assign s_axi_bresp   = br_ff;
    assign s_axi_rvalid  = rv_ff;
    assign s_axi_rdata   = rd_ff;
    assign s_axi_rresp   = rr_ff;
    assign do_wr         = aw_ff && w_ff && !bv_ff;

    // Bus slave and register writes
    always_comb begin
        nxt_aw  = aw_ff;
        nxt_awa = awa_ff;
        nxt_w   = w_ff;
        nxt_wd  = wd_ff;
        nxt_ws  = ws_ff;
        nxt_bv  = bv_ff && !s_axi_bready;
        nxt_br  = br_ff;
        nxt_rv  = rv_ff && !s_axi_rready;
        nxt_rd  = rd_ff;
        nxt_rr  = rr_ff;
        nxt_ctrl = ctrl_ff;
        freset  = 1'b0;
        cfg_off = 8'h00;
        for (int i = 0; i < `CFG_N; i++) begin
            nxt_cfg[i] = cfg_ff[i];
        end
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw  = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w  = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = `RESP_OKAY;
            cfg_off = awa_ff - `ADDR_CFG_BASE;
            if (awa_ff == `ADDR_CTRL) begin
                nxt_ctrl = ws_ff[0] ? wd_ff[7:0] : ctrl_ff;
            end else if (awa_ff == `ADDR_FRESET) begin
                freset = ws_ff[0] && (wd_ff[15:0] == 16'h0001);
            end else if (awa_ff >= `ADDR_CFG_BASE && cfg_off[1:0] == 2'b00
                         && cfg_off[7:2] < 6'(`CFG_N)) begin
                nxt_cfg[cfg_off[5:2]] = merge(cfg_ff[cfg_off[5:2]], wd_ff, ws_ff);
            end else if (awa_ff != `ADDR_WARN && awa_ff != `ADDR_FAULT
                         && awa_ff != `ADDR_STATE) begin
                nxt_br = `RESP_SLVERR;
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rv  = 1'b1;
            nxt_rr  = `RESP_OKAY;
            nxt_rd  = 32'h0000_0000;
            cfg_off = s_axi_araddr - `ADDR_CFG_BASE;
            if (s_axi_araddr == `ADDR_CTRL) begin
                nxt_rd = {24'h00_0000, ctrl_ff};
            end else if (s_axi_araddr == `ADDR_WARN) begin
                nxt_rd = {20'h0_0000, warn_ff};
            end else if (s_axi_araddr == `ADDR_FAULT) begin
                nxt_rd = {17'h0_0000, fault_ff};
            end else if (s_axi_araddr == `ADDR_STATE) begin
                nxt_rd = {25'h000_0000, state_ff};
            end else if (s_axi_araddr >= `ADDR_CFG_BASE && cfg_off[1:0] == 2'b00
                         && cfg_off[7:2] < 6'(`CFG_N)) begin
                nxt_rd = cfg_ff[cfg_off[5:2]];
            end else if (s_axi_araddr != `ADDR_FRESET) begin
                nxt_rr = `RESP_SLVERR;
            end
        end
    end

    // Bus and configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff   <= 1'b0;
            awa_ff  <= 8'h00;
            w_ff    <= 1'b0;
            wd_ff   <= 32'h0000_0000;
            ws_ff   <= 4'h0;
            bv_ff   <= 1'b0;
            br_ff   <= `RESP_OKAY;
            rv_ff   <= 1'b0;
            rd_ff   <= 32'h0000_0000;
            rr_ff   <= `RESP_OKAY;
            ctrl_ff <= `CTRL_RST;
            for (int i = 0; i < `CFG_N; i++) begin
                cfg_ff[i] <= (i >= 10) ? `CFG_TO_RST : `CFG_TH_RST;
            end
        end else begin
            aw_ff   <= nxt_aw;
            awa_ff  <= nxt_awa;
            w_ff    <= nxt_w;
            wd_ff   <= nxt_wd;
            ws_ff   <= nxt_ws;
            bv_ff   <= nxt_bv;
            br_ff   <= nxt_br;
            rv_ff   <= nxt_rv;
            rd_ff   <= nxt_rd;
            rr_ff   <= nxt_rr;
            ctrl_ff <= nxt_ctrl;
            for (int i = 0; i < `CFG_N; i++) begin
                cfg_ff[i] <= nxt_cfg[i];
            end
        end
    end

    logic [7:0]  tick_ff, nxt_tick;
    logic [31:0] pc_ff, nxt_pc, can_ff, nxt_can;
    logic        tick, pc_to, can_to, clr, mt_en;

    assign tick  = tick_ff == 8'(`TICK_CYC - 1);
    assign mt_en = ctrl_ff[`CTRL_MT_EN];
    assign pc_to = state_ff == st_charging && cfg_ff[`CFG_PRECHG_TO] != 32'h0
                   && pc_ff >= cfg_ff[`CFG_PRECHG_TO];
    assign can_to = cfg_ff[`CFG_CAN_TO] != 32'h0 && can_ff > cfg_ff[`CFG_CAN_TO];
    assign clr   = freset || pin_s.fault_clr;

    // Fault sources
    always_comb begin
        src[0]  = pin_s.desat;
        src[1]  = pin_s.gate_fault;
        src[2]  = pin_s.hw_ovp;
        src[3]  = meas.inv_temp > `INV_FAULT_TH;
        src[4]  = meas.pcb_temp > `PCB_FAULT_TH;
        src[5]  = meas.current > cfg_ff[`CFG_CUR_FAULT][15:0];
        src[6]  = mt_en && meas.mot_temp > cfg_ff[`CFG_MT_FAULT][15:0];
        src[7]  = meas.speed > cfg_ff[`CFG_SPD_FAULT][15:0];
        src[8]  = ctrl_ff[`CTRL_PM_MOTOR] && evt.turn_on
                  && meas.speed > cfg_ff[`CFG_ALIGN_MAX][15:0];
        src[9]  = pc_to;
        src[10] = meas.dc_volt > cfg_ff[`CFG_DC_FAULT][15:0];
        src[11] = evt.crc_err;
        src[12] = evt.cal_fail;
        src[13] = can_to;
        src[14] = pin_s.interlock;
    end

    // Warnings, fault latch, timers and drive sequencer
    always_comb begin
        nxt_warn[0]  = hyst(warn_ff[0], meas.inv_temp, `INV_WARN_SET, `INV_WARN_CLR);
        nxt_warn[1]  = hyst(warn_ff[1], meas.pcb_temp, `PCB_WARN_SET, `PCB_WARN_CLR);
        nxt_warn[2]  = hyst(warn_ff[2], meas.current, cfg_ff[`CFG_CUR_WARN][15:0],
                            clr_lvl(cfg_ff[`CFG_CUR_WARN]));
        nxt_warn[3]  = mt_en && hyst(warn_ff[3], meas.mot_temp, cfg_ff[`CFG_MT_WARN][15:0],
                            clr_lvl(cfg_ff[`CFG_MT_WARN]));
        nxt_warn[4]  = hyst(warn_ff[4], meas.speed, cfg_ff[`CFG_SPD_WARN][15:0],
                            clr_lvl(cfg_ff[`CFG_SPD_WARN]));
        nxt_warn[5]  = ctrl_ff[`CTRL_PROF_EN] && meas.torque_req > meas.profile_max;
        nxt_warn[6]  = (ctrl_ff[`CTRL_DER_MOT] && evt.derate_mot)
                       || (ctrl_ff[`CTRL_DER_INV] && evt.derate_inv);
        nxt_warn[7]  = ctrl_ff[`CTRL_FOLD_EN] && evt.foldback;
        nxt_warn[8]  = hyst(warn_ff[8], meas.dc_volt, cfg_ff[`CFG_DC_WARN][15:0],
                            clr_lvl(cfg_ff[`CFG_DC_WARN]));
        nxt_warn[9]  = in_zone(meas.command, cfg_ff[`CFG_SKIP01][15:0],
                               cfg_ff[`CFG_SKIP2][31:16])
                       || in_zone(meas.command, cfg_ff[`CFG_SKIP01][31:16],
                                  cfg_ff[`CFG_SKIP2][31:16])
                       || in_zone(meas.command, cfg_ff[`CFG_SKIP2][15:0],
                                  cfg_ff[`CFG_SKIP2][31:16]);
        nxt_warn[10] = pin_s.rail15_bad;
        nxt_warn[11] = pin_s.rail5_bad;
        // Clear keeps only the CRC fault, then live sources latch again
        nxt_fault = (clr ? (fault_ff & `FAULT_KEEP) : fault_ff) | src;
        nxt_tick  = tick ? 8'h00 : tick_ff + 8'h01;
        nxt_pc    = (state_ff != st_charging) ? 32'h0
                    : (tick && !pc_to) ? pc_ff + 32'h1 : pc_ff;
        nxt_can   = evt.can_rx ? 32'h0
                    : (tick && !can_to) ? can_ff + 32'h1 : can_ff;
        nxt_state = state_ff;
        unique case (state_ff)
            st_init: nxt_state = st_calibrate;
            st_calibrate: if (evt.cal_done) begin
                nxt_state = st_chg_wait;
            end
            st_chg_wait: if (evt.charge_start || !ctrl_ff[`CTRL_PRECHG_EN]) begin
                nxt_state = st_charging;
            end
            st_charging: if (meas.dc_volt >= cfg_ff[`CFG_CONNECT_V][15:0]) begin
                nxt_state = st_idle;
            end
            st_idle: if (evt.turn_on) begin
                nxt_state = st_run;
            end else if (evt.cal_req) begin
                nxt_state = st_calibrate;
            end
            st_run: if (evt.turn_off) begin
                nxt_state = st_idle;
            end
            st_fault: if (clr && nxt_fault == 15'h0000) begin
                nxt_state = evt.cal_req ? st_calibrate : st_chg_wait;
            end
        endcase
        if (nxt_fault != 15'h0000) begin
            nxt_state = st_fault;
        end
    end

    // Monitor registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warn_ff  <= 12'h000;
            fault_ff <= 15'h0000;
            tick_ff  <= 8'h00;
            pc_ff    <= 32'h0000_0000;
            can_ff   <= 32'h0000_0000;
            state_ff <= st_init;
            torque_applied_ff <= 16'h0000;
        end else begin
            warn_ff  <= nxt_warn;
            fault_ff <= nxt_fault;
            tick_ff  <= nxt_tick;
            pc_ff    <= nxt_pc;
            can_ff   <= nxt_can;
            state_ff <= nxt_state;
            torque_applied_ff <= nxt_warn[5] ? meas.profile_max : meas.torque_req;
        end
    end

    // Inverter drops the same cycle a source appears; warnings play no part
    assign inverter_en = state_ff == st_run && src == 15'h0000
                         && fault_ff == 15'h0000;
    assign drive_state = state_ff;
    assign warn_word   = warn_ff;
    assign fault_word  = fault_ff;

    property p_inv_off;
        @(posedge aclk) disable iff (!aresetn) (src != 15'h0000) |-> !inverter_en;
    endproperty
    a_inv_off: assert property (p_inv_off) else $error("inverter on with fault");
    property p_fault_state;
        @(posedge aclk) disable iff (!aresetn) (src != 15'h0000) |=> state_ff == st_fault;
    endproperty
    a_fault_state: assert property (p_fault_state) else $error("no fault state");
    property p_persist;
        @(posedge aclk) disable iff (!aresetn)
            (fault_ff[3] && !clr) |=> fault_ff[3];
    endproperty
    a_persist: assert property (p_persist) else $error("fault dropped");
    property p_crc_keep;
        @(posedge aclk) disable iff (!aresetn) fault_ff[11] |=> fault_ff[11];
    endproperty
    a_crc_keep: assert property (p_crc_keep) else $error("crc fault cleared");
    property p_exit;
        @(posedge aclk) disable iff (!aresetn)
            (state_ff == st_fault && clr && src == 15'h0000 && !fault_ff[11]
             && !evt.cal_req) |=> state_ff == st_chg_wait && fault_ff == 15'h0000;
    endproperty
    a_exit: assert property (p_exit) else $error("bad fault exit");
    property p_inv_warn;
        @(posedge aclk) disable iff (!aresetn)
            (warn_ff[0] && meas.inv_temp >= `INV_WARN_CLR) |=> warn_ff[0];
    endproperty
    a_inv_warn: assert property (p_inv_warn) else $error("inv warn early clear");
    property p_pcb_warn;
        @(posedge aclk) disable iff (!aresetn)
            (!warn_ff[1] && meas.pcb_temp > `PCB_WARN_SET) |=> warn_ff[1];
    endproperty
    a_pcb_warn: assert property (p_pcb_warn) else $error("pcb warn missing");
    property p_mt_off;
        @(posedge aclk) disable iff (!aresetn)
            !mt_en |=> !warn_ff[3] && !fault_ff[6] || $past(fault_ff[6]);
    endproperty
    a_mt_off: assert property (p_mt_off) else $error("motor temp while off");
    property p_clamp;
        @(posedge aclk) disable iff (!aresetn)
            warn_ff[5] |-> torque_applied_ff == $past(meas.profile_max);
    endproperty
    a_clamp: assert property (p_clamp) else $error("torque not clamped");
    property p_rail;
        @(posedge aclk) disable iff (!aresetn) pins.rail5_bad [*3] |=> warn_ff[11];
    endproperty
    a_rail: assert property (p_rail) else $error("rail flag missing");
    property p_bresp;
        @(posedge aclk) disable iff (!aresetn) do_wr |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("no write response");

    c_fault_exit: cover property (@(posedge aclk) disable iff (!aresetn)
        state_ff == st_fault ##1 state_ff == st_chg_wait);
    c_run: cover property (@(posedge aclk) disable iff (!aresetn) inverter_en);
    c_can_to: cover property (@(posedge aclk) disable iff (!aresetn) fault_ff[13]);
endmodule

//--- test/drive_env_model.sv
// Far-side model: measurement sources, hardware pins and drive events
`timescale 1ns/1ps
module drive_env_model (
    // Clock
    input  wire logic                   aclk,
    // Stimulus toward the monitor
    output fault_monitor_pkg::meas_type meas,
    output fault_monitor_pkg::pins_type pins,
    output fault_monitor_pkg::evt_type  evt
);
    import fault_monitor_pkg::*;

    // Quiet sources at start: cool, no pins, no events
    initial begin
        meas = '0;
        pins = '0;
        evt  = '0;
    end

    // One-cycle event pulse, launched just after an edge
    task automatic pulse(input evt_type e);
        @(posedge aclk);
        evt <= e;
        @(posedge aclk);
        evt <= '0;
    endtask
endmodule

//--- test/test_drive_fault_warning_monitor.sv
// Self-checking bench for the fault and warning monitor
`timescale 1ns/1ps
`include "fault_monitor_cfg.svh"
module test_drive_fault_warning_monitor;
    import fault_monitor_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        inverter_en;
    logic [15:0] torque_applied_ff;
    logic [11:0] warn_word;
    logic [14:0] fault_word;
    state_type   drive_state;
    meas_type    meas;
    pins_type    pins;
    evt_type     evt;
    int          n_errors = 0, check_count = 0, cycles = 0;

    drive_env_model env_u (.aclk, .meas, .pins, .evt);
    drive_fault_warning_monitor dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .meas, .pins, .evt, .inverter_en, .torque_applied_ff, .drive_state, .warn_word,
        .fault_word);

    // Clock and hang guard
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask

    // AXI4-Lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
    endtask

    // AXI4-Lite read with expected data and response
    task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = `RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(w, s_axi_rdata, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        env_u.meas.dc_volt <= 16'hFFFF;
        rd("state", `ADDR_STATE, 32'h02);
        rd("fault", `ADDR_FAULT, 32'h0);
        rd("ctrl", `ADDR_CTRL, 32'h0);
        rd("unmapped", 8'h80, 32'h0, `RESP_SLVERR);
        $display("test reset done");
        // Sequence to run, then warnings with hysteresis
        env_u.pulse('{cal_done: 1'b1, default: 1'b0});
        // Let pre-charge reach idle so the turn-on pulse is seen there
        repeat (2) @(posedge aclk);
        env_u.pulse('{turn_on: 1'b1, default: 1'b0});
        rd("state", `ADDR_STATE, 32'h20);
        env_u.meas.inv_temp <= 16'd111;
        rd("warn", `ADDR_WARN, 32'h1);
        chk("inverter_en", {31'h0, inverter_en}, 32'h1);
        env_u.meas.inv_temp <= 16'd106;
        rd("warn", `ADDR_WARN, 32'h1);
        env_u.meas.inv_temp <= 16'd104;
        rd("warn", `ADDR_WARN, 32'h0);
        $display("test warning done");
        // Over-temperature fault, latch and reset request
        env_u.meas.inv_temp <= 16'd116;
        rd("fault", `ADDR_FAULT, 32'h8);
        chk("inverter_en", {31'h0, inverter_en}, 32'h0);
        chk("drive_state", {25'h0, drive_state}, {25'h0, st_fault});
        env_u.meas.inv_temp <= 16'd20;
        rd("fault", `ADDR_FAULT, 32'h8);
        wr(`ADDR_FRESET, 32'h0);
        rd("fault", `ADDR_FAULT, 32'h8);
        env_u.evt.cal_req <= 1'b1;
        wr(`ADDR_FRESET, 32'h1);
        rd("fault", `ADDR_FAULT, 32'h0);
        rd("state", `ADDR_STATE, 32'h02);
        env_u.evt.cal_req <= 1'b0;
        $display("test fault reset done");
        // Live interlock re-latches, then hardware clear
        env_u.pins.interlock <= 1'b1;
        env_u.pins.rail15_bad <= 1'b1;
        env_u.pins.rail5_bad <= 1'b1;
        repeat (4) @(posedge aclk);
        rd("fault", `ADDR_FAULT, 32'h4000);
        chk("fault_word", {17'h0, fault_word}, 32'h4000);
        rd("warn", `ADDR_WARN, 32'hC00);
        chk("warn_word", {20'h0, warn_word}, 32'hC00);
        wr(`ADDR_FRESET, 32'h1);
        rd("fault", `ADDR_FAULT, 32'h4000);
        env_u.pins.interlock <= 1'b0;
        env_u.pins.rail15_bad <= 1'b0;
        env_u.pins.rail5_bad <= 1'b0;
        env_u.pins.fault_clr <= 1'b1;
        repeat (5) @(posedge aclk);
        rd("fault", `ADDR_FAULT, 32'h0);
        $display("test interlock done");
        // Configuration memory error survives every clear
        env_u.pulse('{crc_err: 1'b1, default: 1'b0});
        rd("fault", `ADDR_FAULT, 32'h800);
        env_u.pins.fault_clr <= 1'b0;
        wr(`ADDR_FRESET, 32'h1);
        rd("fault", `ADDR_FAULT, 32'h800);
        $display("test crc done");
        // Torque profile clamp and its release
        wr(`ADDR_CTRL, 32'h02);
        env_u.meas.profile_max <= 16'd200;
        env_u.meas.torque_req <= 16'd300;
        rd("warn", `ADDR_WARN, 32'h20);
        chk("torque", {16'h0, torque_applied_ff}, 32'd200);
        env_u.meas.torque_req <= 16'd150;
        rd("warn", `ADDR_WARN, 32'h0);
        chk("torque", {16'h0, torque_applied_ff}, 32'd150);
        $display("test clamp done");
        // Configured current warning with recovery delta, then fault
        wr(`ADDR_CFG_BASE + 8'h00, 32'h000A_0032);
        wr(`ADDR_CFG_BASE + 8'h04, 32'h0000_0064);
        env_u.meas.current <= 16'd51;
        rd("warn", `ADDR_WARN, 32'h4);
        env_u.meas.current <= 16'd41;
        rd("warn", `ADDR_WARN, 32'h4);
        env_u.meas.current <= 16'd39;
        rd("warn", `ADDR_WARN, 32'h0);
        env_u.meas.current <= 16'd101;
        rd("fault", `ADDR_FAULT, 32'h820);
        $display("test current done");
        end_sim();
    end
endmodule
